//--- logic/dms_pkg.sv
// Constants and types shared by the drive mode selector.
// Assumes a single 25 MHz system clock and asynchronous digital control inputs.
// Functional notes
// - Select input high: automatic; low: manual.
// - Automatic-to-automatic change keeps motor running.
// - Manual/automatic change halts, loads settings, resumes.
// - Faults during change use error class response.
// - Jog starts only at standstill, no fault.
// - Toggle low: first mode; high: second mode.
// - Gear mode needs module in first slot.
// - Pair setting visible only with gear module.
package dms_pkg;

  // Active control modes reported to the drive core.
  typedef enum logic [1:0] {
    DMS_MODE_MANUAL,
    DMS_MODE_SPEED,
    DMS_MODE_CURRENT,
    DMS_MODE_GEAR
  } dms_mode_t;

  // Automatic pair setting encodings and value after reset.
  localparam logic [1:0] DMS_PAIR_SPD_CUR = 2'h0;
  localparam logic [1:0] DMS_PAIR_GEAR_SPD = 2'h1;
  localparam logic [1:0] DMS_PAIR_GEAR_CUR = 2'h2;
  localparam logic [1:0] DMS_PAIR_RESET = 2'h1;

  // Cycles the halt is held before the new mode's settings are loaded.
  localparam int unsigned DMS_HALT_NS = 1000;
  localparam int unsigned DMS_CLK_NS = 40;
  localparam logic [7:0] DMS_HALT_CYC = 8'((DMS_HALT_NS + DMS_CLK_NS - 1) / DMS_CLK_NS);

  // Digital control inputs travelling together.
  typedef struct packed {
    logic auto_manual_select;
    logic auto_pair_toggle_input;
    logic jog_ccw_request;
    logic jog_cw_request;
  } dms_inputs_t;

endpackage

//--- logic/dms_sync_bit.sv
// Two-stage input synchroniser for one control bit.
// Assumes asynchronous active-low reset; output resets low (unconnected input reads low).
`timescale 1ns/1ps
module dms_sync_bit (
  input  wire logic I_SYS_CLK,
  input  wire logic I_RST_B,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_reg;

  // Only the second stage reads the first stage.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      meta_reg <= 1'b0;
      o_q      <= 1'b0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule // dms_sync_bit

//--- logic/dms_mode_selector.sv
// Drive mode selector: decides manual or automatic mode and sequences changes.
// Assumes a drive core that reports standstill and faults and consumes the mode.
`timescale 1ns/1ps
module dms_mode_selector
  import dms_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_B,
  input  wire dms_inputs_t i_inputs,
  input  wire logic        i_hmi_jog_request,
  input  wire logic        i_motor_standstill,
  input  wire logic        i_fault_pending,
  input  wire logic        i_slot1_gear_module,
  input  wire logic        i_pair_write,
  input  wire logic [1:0]  i_pair_wdata,
  input  wire logic [1:0]  i_pair_stored,
  input  wire logic        i_pair_stored_valid,
  output dms_mode_t        o_mode,
  output logic             o_halt,
  output logic             o_load_settings,
  output logic             o_jog_active,
  output logic             o_jog_dir_cw,
  output logic [1:0]       o_auto_pair_setting,
  output logic             o_pair_visible,
  output logic             o_pair_persist
);

  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_LOAD, ST_FAULT} dms_state_t;

  logic       sel_sync, tog_sync, ccw_sync, cw_sync;
  logic [1:0] pair_reg;
  logic       pair_load_reg;
  dms_state_t state_reg;
  logic [7:0] halt_cnt_reg;
  logic       auto_reg;
  dms_mode_t  auto_mode;
  logic       jog_req;

  // Control inputs are resynchronised before any decision is made.
  dms_sync_bit u_sync_sel (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .i_d(i_inputs.auto_manual_select), .o_q(sel_sync));
  dms_sync_bit u_sync_tog (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .i_d(i_inputs.auto_pair_toggle_input), .o_q(tog_sync));
  dms_sync_bit u_sync_ccw (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .i_d(i_inputs.jog_ccw_request), .o_q(ccw_sync));
  dms_sync_bit u_sync_cw  (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .i_d(i_inputs.jog_cw_request), .o_q(cw_sync));

  // Pair setting: taken once from non-volatile storage after reset, then
  // written only while a gear module is fitted; out-of-range values ignored.
  // Writes are ignored until the stored value is taken, so an early write is dropped.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pair_reg      <= DMS_PAIR_RESET;
      pair_load_reg <= 1'b0;
    end else if (!pair_load_reg && i_pair_stored_valid) begin
      pair_load_reg <= 1'b1;
      if (i_pair_stored <= DMS_PAIR_GEAR_CUR) begin
        pair_reg <= i_pair_stored;
      end
    end else if (pair_load_reg && i_pair_write && i_slot1_gear_module
                 && i_pair_wdata <= DMS_PAIR_GEAR_CUR) begin
      pair_reg <= i_pair_wdata;
    end
  end

  // Persist strobe tells storage to retain an accepted write.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_pair_persist <= 1'b0;
    end else begin
      o_pair_persist <= pair_load_reg && i_pair_write && i_slot1_gear_module
                        && (i_pair_wdata <= DMS_PAIR_GEAR_CUR);
    end
  end

  assign o_auto_pair_setting = pair_reg;

  // Visibility is registered like the other status outputs; it trails the
  // module-present input by one cycle, far below what any display notices.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_pair_visible <= 1'b0;
    end else begin
      o_pair_visible <= i_slot1_gear_module;
    end
  end

  // Automatic mode from pair and toggle; without a gear module the gear
  // choice falls back to speed/current so no unavailable mode is entered.
  always_comb begin
    auto_mode = DMS_MODE_SPEED;
    case (i_slot1_gear_module ? pair_reg : DMS_PAIR_SPD_CUR)
      DMS_PAIR_SPD_CUR:  auto_mode = tog_sync ? DMS_MODE_CURRENT : DMS_MODE_SPEED;
      DMS_PAIR_GEAR_SPD: auto_mode = tog_sync ? DMS_MODE_SPEED : DMS_MODE_GEAR;
      DMS_PAIR_GEAR_CUR: auto_mode = tog_sync ? DMS_MODE_CURRENT : DMS_MODE_GEAR;
      default:           auto_mode = DMS_MODE_SPEED;
    endcase
  end

  // Change sequencer: manual/automatic changes halt the motor, wait for
  // standstill plus a minimum hold, load the settings, then resume.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg    <= ST_RUN;
      halt_cnt_reg <= 8'h00;
      auto_reg     <= 1'b0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (sel_sync != auto_reg) begin
            state_reg    <= ST_HALT;
            halt_cnt_reg <= DMS_HALT_CYC;
          end
        end
        ST_HALT: begin
          if (i_fault_pending) begin
            state_reg <= ST_FAULT;
          end else if (halt_cnt_reg != 8'h00) begin
            halt_cnt_reg <= halt_cnt_reg - 8'h01;
          end else if (i_motor_standstill) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          auto_reg  <= sel_sync;
          state_reg <= ST_RUN;
        end
        ST_FAULT: begin
          // The error-class response owns the motor until the fault clears.
          if (!i_fault_pending) begin
            state_reg    <= ST_HALT;
            halt_cnt_reg <= DMS_HALT_CYC;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // Jog start: manual, settled, standstill, no fault; held while requested.
  assign jog_req = ccw_sync || cw_sync || i_hmi_jog_request;
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_jog_active <= 1'b0;
      o_jog_dir_cw <= 1'b0;
    end else if (auto_reg || state_reg != ST_RUN || i_fault_pending || !jog_req) begin
      o_jog_active <= 1'b0;
    end else if (!o_jog_active && i_motor_standstill) begin
      o_jog_active <= 1'b1;
      o_jog_dir_cw <= cw_sync && !ccw_sync;
    end
  end

  // Mode output: automatic modes follow the toggle directly, no halt.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_mode          <= DMS_MODE_MANUAL;
      o_halt          <= 1'b0;
      o_load_settings <= 1'b0;
    end else begin
      o_halt          <= (state_reg == ST_HALT) || (state_reg == ST_FAULT);
      o_load_settings <= (state_reg == ST_LOAD);
      if (state_reg == ST_RUN) begin
        o_mode <= auto_reg ? auto_mode : DMS_MODE_MANUAL;
      end
    end
  end

  // Assertions.
  auto_no_halt_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (state_reg == ST_RUN && auto_reg && sel_sync && $changed(tog_sync)) |=> ##1 !o_halt)
    else $error("Automatic mode change halted the motor");
  change_halts_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (state_reg == ST_RUN && sel_sync != auto_reg) |=> ##1 o_halt)
    else $error("Manual/automatic change did not halt");
  load_after_halt_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $rose(o_load_settings) |-> $past(o_halt))
    else $error("Settings loaded without halt");
  fault_holds_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (state_reg == ST_HALT && i_fault_pending) |=> state_reg == ST_FAULT)
    else $error("Fault during change not handled");
  jog_start_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $rose(o_jog_active) |-> $past(i_motor_standstill && !i_fault_pending && jog_req))
    else $error("Jog started without standstill or request");
  pair_range_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    pair_reg <= DMS_PAIR_GEAR_CUR)
    else $error("Pair setting out of range");
  toggle_pair_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (state_reg == ST_RUN && auto_reg && i_slot1_gear_module && pair_reg == DMS_PAIR_SPD_CUR
     && tog_sync) |=> o_mode == DMS_MODE_CURRENT)
    else $error("Toggle high did not select second mode");
  no_gear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (!i_slot1_gear_module && state_reg == ST_RUN) |=> o_mode != DMS_MODE_GEAR)
    else $error("Gear mode without module");
  jog_auto_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    auto_reg |=> !o_jog_active)
    else $error("Jog active in automatic mode");

  // Assertions on what the drive core and the configuration tools see.
  manual_mode_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    (state_reg == ST_RUN && !auto_reg) |=> o_mode == DMS_MODE_MANUAL)
    else $error("Manual selection did not give manual mode");
  load_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    o_load_settings |=> !o_load_settings)
    else $error("Settings load lasted more than one cycle");
  pair_hidden_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    !i_slot1_gear_module |=> !o_pair_visible)
    else $error("Pair setting shown without gear module");
  pair_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $changed(pair_reg) |-> ($past(i_slot1_gear_module) || !$past(pair_load_reg)))
    else $error("Pair setting changed without gear module");
  persist_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    o_pair_persist |-> $past(i_slot1_gear_module))
    else $error("Pair setting persisted without gear module");

  manual_to_auto_c: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $rose(auto_reg));
  jog_run_c: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $rose(o_jog_active));
  fault_change_c: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    state_reg == ST_FAULT);
  auto_toggle_c: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    state_reg == ST_RUN && auto_reg && $changed(tog_sync));
  pair_write_c: cover property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
    $rose(o_pair_persist));

endmodule // dms_mode_selector

//--- testbench/dms_panel_model.sv
// Switch panel and motor model on the far side of the mode selector.
// Assumes the bench sets switch levels; the motor follows the selector outputs.
`timescale 1ns/1ps
module dms_panel_model
  import dms_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST_B,
  input  wire logic       i_sel,
  input  wire logic       i_tog,
  input  wire logic [1:0] i_jog,
  input  wire dms_mode_t  i_mode,
  input  wire logic       i_halt,
  input  wire logic       i_jog_active,
  output dms_inputs_t     o_inputs,
  output logic            o_standstill
);
  logic [1:0] stop_reg;
  // Switch levels travel as one struct; an open switch reads low.
  assign o_inputs = '{i_sel, i_tog, i_jog[1], i_jog[0]};
  // The motor coasts two cycles before it reports standstill, so no halt is instant.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) stop_reg <= 2'h3;
    else stop_reg <= {stop_reg[0], !i_jog_active && (i_halt || i_mode == DMS_MODE_MANUAL)};
  end
  assign o_standstill = stop_reg[1];
endmodule // dms_panel_model

//--- testbench/dms_mode_selector_tb_top.sv
// Self-checking bench for the drive mode selector.
// Assumes the panel model beside it; inputs change on the falling edge.
`timescale 1ns/1ps
module dms_mode_selector_tb_top;
  import dms_pkg::*;
  logic clk = 0, rst_b = 0, sel = 0, tog = 0, hmi = 0, fault = 0, mod = 0;
  logic pw = 0, pval = 0, still, halt, load, ja, cw, vis, per;
  logic [1:0] jog = 0, wd = 0, pset;
  dms_inputs_t inp;
  dms_mode_t mode;
  int mismatches = 0, samples_checked = 0, n_load = 0, n_per = 0, n_hcyc = 0;
  dms_mode_t exp_m [3][2] = '{'{DMS_MODE_SPEED, DMS_MODE_CURRENT},
    '{DMS_MODE_GEAR, DMS_MODE_SPEED}, '{DMS_MODE_GEAR, DMS_MODE_CURRENT}};
  dms_panel_model u_panel (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_sel(sel), .i_tog(tog),
    .i_jog(jog), .i_mode(mode), .i_halt(halt), .i_jog_active(ja), .o_inputs(inp),
    .o_standstill(still));
  dms_mode_selector dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_inputs(inp),
    .i_hmi_jog_request(hmi), .i_motor_standstill(still), .i_fault_pending(fault),
    .i_slot1_gear_module(mod), .i_pair_write(pw), .i_pair_wdata(wd), .i_pair_stored(2'h2),
    .i_pair_stored_valid(pval), .o_mode(mode), .o_halt(halt), .o_load_settings(load),
    .o_jog_active(ja), .o_jog_dir_cw(cw), .o_auto_pair_setting(pset), .o_pair_visible(vis),
    .o_pair_persist(per));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  // Pulses are counted at the edge, so a one-cycle output is never missed.
  always @(posedge clk) begin
    if (load === 1'b1) n_load++;
    if (per === 1'b1) n_per++;
    if (halt === 1'b1) n_hcyc++;
  end
  task automatic chk(string n, logic [1:0] s, logic [1:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic set_pair(logic [1:0] v);
    wd = v;
    pw = 1;
    cyc(1);
    pw = 0;
    cyc(2);
  endtask
  // A manual/automatic change must halt for the full hold, then load once.
  task automatic change(dms_mode_t m);
    int k, h;
    k = n_load;
    h = n_hcyc;
    repeat (200) if (n_load == k) cyc(1);
    cyc(2);
    chk("load", 2'(n_load - k), 2'h1);
    chk("halt", 2'(n_hcyc - h >= DMS_HALT_CYC), 2'h1);
    chk("mode", mode, m);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The whole sequence needs about 250 cycles; the watchdog allows far more.
  initial begin
    #400us;
    mismatches++;
    finish_test();
  end
  initial begin
    int h;
    cyc(16);
    rst_b = 1;
    cyc(1);
    chk("mode", mode, DMS_MODE_MANUAL);
    chk("pair", pset, DMS_PAIR_RESET);
    chk("vis", vis, 2'h0);
    pval = 1;
    cyc(1);
    pval = 0;
    cyc(2);
    chk("pair", pset, 2'h2);
    set_pair(2'h0);
    chk("pair", pset, 2'h2);
    mod = 1;
    cyc(1);
    chk("vis", vis, 2'h1);
    set_pair(2'h3);
    chk("pair", pset, 2'h2);
    set_pair(2'h0);
    chk("pair", pset, 2'h0);
    chk("persist", 2'(n_per), 2'h1);
    fault = 1;
    jog = 2'b10;
    cyc(8);
    chk("jog", ja, 2'h0);
    fault = 0;
    jog = 0;
    cyc(4);
    for (int i = 0; i < 3; i++) begin
      jog = (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00;
      hmi = (i == 2);
      cyc(8);
      chk("jog", ja, 2'h1);
      chk("dir", cw, 2'(i == 1));
      jog = 0;
      hmi = 0;
      cyc(8);
      chk("jog", ja, 2'h0);
    end
    sel = 1;
    change(DMS_MODE_SPEED);
    jog = 2'b10;
    cyc(8);
    chk("jog", ja, 2'h0);
    jog = 0;
    for (int p = 0; p < 3; p++) begin
      set_pair(2'(p));
      for (int t = 0; t < 2; t++) begin
        tog = t[0];
        h = n_hcyc;
        cyc(5);
        chk("mode", mode, exp_m[p][t]);
        chk("halt", 2'(n_hcyc - h), 2'h0);
      end
    end
    mod = 0;
    tog = 0;
    cyc(5);
    chk("mode", mode, DMS_MODE_SPEED);
    sel = 0;
    cyc(8);
    fault = 1;
    h = n_load;
    cyc(40);
    chk("halt", halt, 2'h1);
    chk("load", 2'(n_load - h), 2'h0);
    fault = 0;
    change(DMS_MODE_MANUAL);
    finish_test();
  end
endmodule // dms_mode_selector_tb_top
